// ==== core/rcil_map.svh ====
// Register offsets, field positions, reset values and timing for reset cause logic
`ifndef RCIL_MAP_SVH
`define RCIL_MAP_SVH

`define RCIL_CLK_HZ         25000000
`define RCIL_PWRT_MS        72
`define RCIL_PWRT_CYCLES    ((`RCIL_CLK_HZ / 1000) * `RCIL_PWRT_MS)
`define RCIL_OST_TOSC       1024
`define RCIL_OST_CYCLES     (`RCIL_OST_TOSC)
`define RCIL_CNT_W          21

`define RCIL_PC_W           13
`define RCIL_PC_RESET       13'h0000
`define RCIL_PC_IRQ_VEC     13'h0004
`define RCIL_PC_STEP        13'h0001

`define RCIL_OFS_PWR_STATUS 5'h00
`define RCIL_OFS_CORE_STAT  5'h04
`define RCIL_OFS_CAUSE      5'h08
`define RCIL_OFS_IRQ_STAT   5'h0C
`define RCIL_OFS_IRQ_MASK   5'h10
`define RCIL_OFS_OPTION     5'h14

`define RCIL_PWR_RESET      2'h1
`define RCIL_BIT_POWER_ON   1
`define RCIL_BIT_BROWNOUT   0
`define RCIL_STAT_HI_RESET  3'h0
`define RCIL_OPTION_RESET   8'hFF
`define RCIL_EVT_W          6
`define RCIL_EVT_POR        0
`define RCIL_EVT_BOR        1
`define RCIL_EVT_WDT_RST    2
`define RCIL_EVT_WDT_WAKE   3
`define RCIL_EVT_EXT        4
`define RCIL_EVT_IRQ_WAKE   5
`define RCIL_EVT_NONE       6'h00
`define RCIL_SYNC_W         3
`define RCIL_SYNC_RST       3'h4

`endif

// ==== core/rcil_pkg.sv ====
// Types shared by the reset cause and init logic
package rcil_pkg;

  typedef enum logic [1:0] {
    OSC_CRYSTAL_SLOW,
    OSC_CRYSTAL_MID,
    OSC_CRYSTAL_FAST,
    OSC_RES_CAP
  } rcil_osc_t;

  typedef enum logic [2:0] {
    CAUSE_POWER_ON,
    CAUSE_BROWNOUT,
    CAUSE_WDT_RESET,
    CAUSE_WDT_WAKE,
    CAUSE_EXT_RUN,
    CAUSE_EXT_SLEEP,
    CAUSE_IRQ_WAKE
  } rcil_cause_t;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_HOLD,
    ST_PWRT,
    ST_OST,
    ST_RUN,
    ST_SLEEP
  } rcil_state_t;

endpackage : rcil_pkg

// ==== core/rcil_core.sv ====
// Reset cause recording, start-up time-out sequencer and reset init values
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "rcil_map.svh"

module rcil_core #(
  parameter int PWRT_CYCLES = `RCIL_PWRT_CYCLES,
  parameter int OST_CYCLES  = `RCIL_OST_CYCLES,
  parameter int CNT_W       = `RCIL_CNT_W
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   external_reset_pin_n,
  input  wire logic                   brownout_detect,
  input  wire logic                   watchdog_timeout,
  input  wire logic                   brownout_detect_enable,
  input  wire logic                   startup_delay_disable,
  input  wire rcil_pkg::rcil_osc_t    osc_mode,
  input  wire logic                   sleep_req,
  input  wire logic                   irq_wake,
  input  wire logic                   global_irq_enable,
  input  wire logic [`RCIL_PC_W-1:0]  pc_current,
  input  wire logic [4:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  output logic                        core_reset_q,
  output logic                        pc_load_q,
  output logic [`RCIL_PC_W-1:0]       pc_value_q,
  output logic [7:0]                  option_q,
  output logic                        irq_q
);
  import rcil_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [`RCIL_SYNC_W-1:0] async_in;
  logic [`RCIL_SYNC_W-1:0] sync1_q;
  logic [`RCIL_SYNC_W-1:0] sync2_q;
  logic                    wdt_prev_q;
  logic                    pin_n_s;
  logic                    bor_s;
  logic                    wdt_s;

  // Pin idles high, so its stages reset high
  localparam logic [`RCIL_SYNC_W-1:0] SYNC_RST = `RCIL_SYNC_RST;

  assign async_in = {external_reset_pin_n, brownout_detect, watchdog_timeout};

  genvar gi;
  generate
    for (gi = 0; gi < `RCIL_SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          sync1_q[gi] <= SYNC_RST[gi];
          sync2_q[gi] <= SYNC_RST[gi];
        end
        else
        begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign pin_n_s = sync2_q[2];
  assign bor_s   = sync2_q[1];
  assign wdt_s   = sync2_q[0];

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wdt_prev_q <= 1'b0;
    else
      wdt_prev_q <= wdt_s;
  end

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  rcil_state_t st_q;
  rcil_state_t st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             hold_bor_q;
  logic             wake_pend_q;
  logic [`RCIL_PC_W-1:0] target_pc_q;
  logic             crystal;
  logic             wdt_rise;
  logic             bor_evt;
  logic             ext_run_evt;
  logic             ext_sleep_evt;
  logic             wdt_rst_evt;
  logic             wdt_wake_evt;
  logic             irq_wake_evt;
  logic             sleep_evt;
  logic             por_evt;
  logic             any_reset;

  assign crystal  = (osc_mode != OSC_RES_CAP);
  assign wdt_rise = wdt_s && !wdt_prev_q;
  assign por_evt  = (st_q == ST_BOOT);

  always_comb
  begin
    bor_evt       = 1'b0;
    ext_run_evt   = 1'b0;
    ext_sleep_evt = 1'b0;
    wdt_rst_evt   = 1'b0;
    wdt_wake_evt  = 1'b0;
    irq_wake_evt  = 1'b0;
    sleep_evt     = 1'b0;
    // Brown-out ignored while detection is off
    if (brownout_detect_enable && bor_s && st_q != ST_BOOT && !(st_q == ST_HOLD && hold_bor_q))
      bor_evt = 1'b1;
    else if (st_q == ST_RUN)
    begin
      if (!pin_n_s)
        ext_run_evt = 1'b1;
      else if (wdt_rise)
        wdt_rst_evt = 1'b1;
      else if (sleep_req)
        sleep_evt = 1'b1;
    end
    else if (st_q == ST_SLEEP)
    begin
      if (!pin_n_s)
        ext_sleep_evt = 1'b1;
      else if (wdt_rise)
        wdt_wake_evt = 1'b1;
      else if (irq_wake)
        irq_wake_evt = 1'b1;
    end
  end

  assign any_reset = bor_evt || ext_run_evt || ext_sleep_evt || wdt_rst_evt;

  // ----------------------------------------
  // Time-out sequencer
  // ----------------------------------------
  always_comb
  begin
    st_d  = st_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    if (any_reset)
    begin
      st_d = ST_HOLD;
    end
    else
    begin
      case (st_q)
        ST_BOOT:
        begin
          if (!startup_delay_disable)
          begin
            st_d  = ST_PWRT;
            cnt_d = CNT_W'(PWRT_CYCLES - 1);
          end
          else if (crystal)
          begin
            st_d  = ST_OST;
            cnt_d = CNT_W'(OST_CYCLES - 1);
          end
          else
            st_d = pin_n_s ? ST_RUN : ST_HOLD;
        end
        ST_HOLD:
        begin
          if (pin_n_s && !(brownout_detect_enable && bor_s))
          begin
            if (hold_bor_q)
            begin
              st_d  = ST_PWRT;
              cnt_d = CNT_W'(PWRT_CYCLES - 1);
            end
            else
              st_d = ST_RUN;
          end
        end
        ST_PWRT:
        begin
          if (cnt_q == '0)
          begin
            if (crystal)
            begin
              st_d  = ST_OST;
              cnt_d = CNT_W'(OST_CYCLES - 1);
            end
            else
              st_d = pin_n_s ? ST_RUN : ST_HOLD;
          end
        end
        ST_OST:
        begin
          if (cnt_q == '0)
            st_d = (pin_n_s || wake_pend_q) ? ST_RUN : ST_HOLD;
        end
        ST_RUN:
        begin
          if (sleep_evt)
            st_d = ST_SLEEP;
        end
        ST_SLEEP:
        begin
          if (wdt_wake_evt || irq_wake_evt)
          begin
            if (crystal)
            begin
              st_d  = ST_OST;
              cnt_d = CNT_W'(OST_CYCLES - 1);
            end
            else
              st_d = ST_RUN;
          end
        end
        default: st_d = ST_BOOT;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q  <= ST_BOOT;
      cnt_q <= '0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hold_bor_q <= 1'b0;
    else if (bor_evt)
      hold_bor_q <= 1'b1;
    else if (any_reset)
      hold_bor_q <= 1'b0;
  end

  // ----------------------------------------
  // Program counter on restart
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wake_pend_q <= 1'b0;
      target_pc_q <= `RCIL_PC_RESET;
    end
    else if (any_reset)
    begin
      wake_pend_q <= 1'b0;
      target_pc_q <= `RCIL_PC_RESET;
    end
    else if (irq_wake_evt && global_irq_enable)
    begin
      wake_pend_q <= 1'b1;
      target_pc_q <= `RCIL_PC_IRQ_VEC;
    end
    else if (wdt_wake_evt || irq_wake_evt)
    begin
      wake_pend_q <= 1'b1;
      target_pc_q <= pc_current + `RCIL_PC_STEP;
    end
    else if (st_q == ST_RUN)
    begin
      wake_pend_q <= 1'b0;
      target_pc_q <= `RCIL_PC_RESET;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      core_reset_q <= 1'b1;
      pc_load_q    <= 1'b0;
      pc_value_q   <= `RCIL_PC_RESET;
    end
    else
    begin
      core_reset_q <= !(st_d == ST_RUN || st_d == ST_SLEEP);
      pc_load_q    <= (st_d == ST_RUN) && (st_q != ST_RUN);
      if ((st_d == ST_RUN) && (st_q != ST_RUN))
        pc_value_q <= target_pc_q;
    end
  end

  // ----------------------------------------
  // Cause flags and status bits
  // ----------------------------------------
  logic [1:0]  pwr_q;
  logic        to_q;
  logic        pd_q;
  logic [2:0]  stat_hi_q;
  rcil_cause_t cause_q;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic        avs_wait_q;

  assign acc    = (avs_read || avs_write) && !avs_wait_q;
  assign wr_acc = acc && avs_write && avs_byteenable[0];
  assign rd_acc = acc && avs_read;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pwr_q <= `RCIL_PWR_RESET;
    else if (bor_evt)
      pwr_q[`RCIL_BIT_BROWNOUT] <= 1'b0;
    else if (wr_acc && avs_address == `RCIL_OFS_PWR_STATUS)
      pwr_q <= avs_writedata[1:0];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end
    else if (bor_evt)
    begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end
    else if (wdt_rst_evt)
    begin
      to_q <= 1'b0;
      pd_q <= 1'b1;
    end
    else if (wdt_wake_evt)
    begin
      to_q <= 1'b0;
      pd_q <= 1'b0;
    end
    else if (ext_sleep_evt || irq_wake_evt)
    begin
      to_q <= 1'b1;
      pd_q <= 1'b0;
    end
    else if (sleep_evt)
    begin
      to_q <= 1'b1;
      pd_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      stat_hi_q <= `RCIL_STAT_HI_RESET;
    else if (any_reset)
      stat_hi_q <= `RCIL_STAT_HI_RESET;
    else if (wr_acc && avs_address == `RCIL_OFS_CORE_STAT)
      stat_hi_q <= avs_writedata[7:5];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      option_q <= `RCIL_OPTION_RESET;
    else if (any_reset)
      option_q <= `RCIL_OPTION_RESET;
    else if (wr_acc && avs_address == `RCIL_OFS_OPTION)
      option_q <= avs_writedata[7:0];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cause_q <= CAUSE_POWER_ON;
    else if (bor_evt)
      cause_q <= CAUSE_BROWNOUT;
    else if (ext_run_evt)
      cause_q <= CAUSE_EXT_RUN;
    else if (ext_sleep_evt)
      cause_q <= CAUSE_EXT_SLEEP;
    else if (wdt_rst_evt)
      cause_q <= CAUSE_WDT_RESET;
    else if (wdt_wake_evt)
      cause_q <= CAUSE_WDT_WAKE;
    else if (irq_wake_evt)
      cause_q <= CAUSE_IRQ_WAKE;
  end

  // ----------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------
  logic [`RCIL_EVT_W-1:0] evt_set;
  logic [`RCIL_EVT_W-1:0] evt_q;
  logic [`RCIL_EVT_W-1:0] mask_q;
  logic [`RCIL_EVT_W-1:0] evt_clr;

  always_comb
  begin
    evt_set = `RCIL_EVT_NONE;
    evt_set[`RCIL_EVT_POR]      = por_evt;
    evt_set[`RCIL_EVT_BOR]      = bor_evt;
    evt_set[`RCIL_EVT_WDT_RST]  = wdt_rst_evt;
    evt_set[`RCIL_EVT_WDT_WAKE] = wdt_wake_evt;
    evt_set[`RCIL_EVT_EXT]      = ext_run_evt || ext_sleep_evt;
    evt_set[`RCIL_EVT_IRQ_WAKE] = irq_wake_evt;
  end

  // Clear only what the read returned; a new set wins
  assign evt_clr = (rd_acc && avs_address == `RCIL_OFS_IRQ_STAT) ?
                   avs_readdata[`RCIL_EVT_W-1:0] : `RCIL_EVT_NONE;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      evt_q <= `RCIL_EVT_NONE;
    else
      evt_q <= (evt_q & ~evt_clr) | evt_set;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mask_q <= `RCIL_EVT_NONE;
    else if (wr_acc && avs_address == `RCIL_OFS_IRQ_MASK)
      mask_q <= avs_writedata[`RCIL_EVT_W-1:0];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_q <= 1'b0;
    else
      irq_q <= |(evt_q & mask_q);
  end

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `RCIL_OFS_PWR_STATUS: rd_mux = {30'h0000_0000, pwr_q};
      `RCIL_OFS_CORE_STAT:  rd_mux = {24'h00_0000, stat_hi_q, to_q, pd_q, 3'h0};
      `RCIL_OFS_CAUSE:      rd_mux = {29'h0000_0000, cause_q};
      `RCIL_OFS_IRQ_STAT:   rd_mux = {26'h000_0000, evt_q};
      `RCIL_OFS_IRQ_MASK:   rd_mux = {26'h000_0000, mask_q};
      `RCIL_OFS_OPTION:     rd_mux = {24'h00_0000, option_q};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      avs_wait_q <= 1'b1;
    else if ((avs_read || avs_write) && avs_wait_q)
      avs_wait_q <= 1'b0;
    else
      avs_wait_q <= 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && avs_wait_q)
      avs_readdata <= rd_mux;
  end

  assign avs_waitrequest = avs_wait_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_por_flag_kept;
    @(posedge clk) disable iff (sys_rst)
      !(wr_acc && avs_address == `RCIL_OFS_PWR_STATUS) |=> $stable(pwr_q[`RCIL_BIT_POWER_ON]);
  endproperty
  a_por_flag_kept: assert property (p_por_flag_kept) else $error("power-on flag moved");

  property p_bor_clear;
    @(posedge clk) disable iff (sys_rst)
      bor_evt |=> !pwr_q[`RCIL_BIT_BROWNOUT] && to_q && pd_q && core_reset_q;
  endproperty
  a_bor_clear: assert property (p_bor_clear) else $error("brown-out flags wrong");

  property p_wdt_reset_flags;
    @(posedge clk) disable iff (sys_rst)
      wdt_rst_evt |=> !to_q && pd_q && option_q == `RCIL_OPTION_RESET;
  endproperty
  a_wdt_reset_flags: assert property (p_wdt_reset_flags) else $error("watchdog reset flags");

  property p_wdt_wake_flags;
    @(posedge clk) disable iff (sys_rst)
      wdt_wake_evt |=> !to_q && !pd_q && $stable(option_q);
  endproperty
  a_wdt_wake_flags: assert property (p_wdt_wake_flags) else $error("watchdog wake flags");

  property p_ext_sleep_flags;
    @(posedge clk) disable iff (sys_rst)
      (ext_sleep_evt || irq_wake_evt) |=> to_q && !pd_q;
  endproperty
  a_ext_sleep_flags: assert property (p_ext_sleep_flags) else $error("sleep reset flags");

  property p_ext_run_flags;
    @(posedge clk) disable iff (sys_rst)
      ext_run_evt |=> $stable(to_q) && $stable(pd_q) && stat_hi_q == `RCIL_STAT_HI_RESET;
  endproperty
  a_ext_run_flags: assert property (p_ext_run_flags) else $error("running pin reset flags");

  property p_hold_release_pc;
    @(posedge clk) disable iff (sys_rst)
      (st_q == ST_HOLD && st_d == ST_RUN) |=> pc_load_q && pc_value_q == `RCIL_PC_RESET;
  endproperty
  a_hold_release_pc: assert property (p_hold_release_pc) else $error("reset pc not zero");

  // Wake to vector load must not outlast the oscillator start-up count plus two
  logic             vec_pend_q;
  logic [CNT_W-1:0] vec_wait_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vec_pend_q <= 1'b0;
      vec_wait_q <= '0;
    end
    else if (irq_wake_evt && global_irq_enable)
    begin
      vec_pend_q <= 1'b1;
      vec_wait_q <= '0;
    end
    else if (pc_load_q || any_reset)
      vec_pend_q <= 1'b0;
    else if (vec_pend_q)
      vec_wait_q <= vec_wait_q + 1'b1;
  end

  property p_irq_vector;
    @(posedge clk) disable iff (sys_rst)
      (vec_pend_q && pc_load_q) |-> pc_value_q == `RCIL_PC_IRQ_VEC;
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("irq vector missing");

  property p_irq_vector_due;
    @(posedge clk) disable iff (sys_rst)
      vec_pend_q |-> vec_wait_q <= CNT_W'(OST_CYCLES + 2);
  endproperty
  a_irq_vector_due: assert property (p_irq_vector_due) else $error("irq vector late");

  property p_wake_marked;
    @(posedge clk) disable iff (sys_rst)
      (wdt_wake_evt || irq_wake_evt) |=> (evt_q[`RCIL_EVT_WDT_WAKE] || evt_q[`RCIL_EVT_IRQ_WAKE]);
  endproperty
  a_wake_marked: assert property (p_wake_marked) else $error("wake source unmarked");

  property p_rc_no_ost;
    @(posedge clk) disable iff (sys_rst)
      (st_q == ST_PWRT && cnt_q == '0 && !crystal) |=> st_q != ST_OST;
  endproperty
  a_rc_no_ost: assert property (p_rc_no_ost) else $error("start-up delay in rc mode");

  c_power_up_run: cover property (@(posedge clk) disable iff (sys_rst)
    st_q == ST_OST && cnt_q == '0 && !wake_pend_q ##1 st_q == ST_RUN);
  c_brownout: cover property (@(posedge clk) disable iff (sys_rst) bor_evt);
  c_wdt_wake: cover property (@(posedge clk) disable iff (sys_rst) wdt_wake_evt);
  c_irq_vector: cover property (@(posedge clk) disable iff (sys_rst)
    irq_wake_evt && global_irq_enable);

endmodule : rcil_core

`default_nettype wire

// ==== tb/rcil_partner.sv ====
// Model of supply monitor, external reset pin and watchdog
`timescale 1ns/10ps
`default_nettype none

module rcil_partner (
  input  wire logic clk,
  output logic      external_reset_pin_n,
  output logic      brownout_detect,
  output logic      watchdog_timeout
);
  // Pin pulled up, supply good, watchdog quiet
  initial
  begin
    external_reset_pin_n = 1'b1;
    brownout_detect      = 1'b0;
    watchdog_timeout     = 1'b0;
  end

  task automatic pin_low(input int n);
    @(posedge clk);
    external_reset_pin_n <= 1'b0;
    repeat (n) @(posedge clk);
    external_reset_pin_n <= 1'b1;
  endtask : pin_low

  task automatic brownout(input int n);
    @(posedge clk);
    brownout_detect <= 1'b1;
    repeat (n) @(posedge clk);
    brownout_detect <= 1'b0;
  endtask : brownout

  task automatic expire();
    @(posedge clk);
    watchdog_timeout <= 1'b1;
    repeat (3) @(posedge clk);
    watchdog_timeout <= 1'b0;
  endtask : expire
endmodule : rcil_partner
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench for the reset cause and init logic
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end

module tb_top;
  import rcil_pkg::*;
  localparam int PWRT = 20;
  localparam int OST  = 8;
  logic               clk;
  logic               sys_rst;
  wire logic          pin_n;
  wire logic          bo;
  wire logic          wd;
  logic               brownout_detect_enable;
  logic               startup_delay_disable;
  rcil_osc_t          osc_mode;
  logic               sleep_req;
  logic               irq_wake;
  logic               global_irq_enable;
  logic [12:0]        pc_current;
  logic [4:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               core_reset_q;
  logic               pc_load_q;
  logic [12:0]        pc_value_q;
  logic [7:0]         option_q;
  logic               irq_q;
  int                 error_cnt;
  int                 comparisons;
  int                 n;
  logic [12:0]        pc;

  rcil_partner u_partner (
    .clk                  (clk),
    .external_reset_pin_n (pin_n),
    .brownout_detect      (bo),
    .watchdog_timeout     (wd)
  );

  rcil_core #(.PWRT_CYCLES(PWRT), .OST_CYCLES(OST)) u_rcil_core (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .external_reset_pin_n   (pin_n),
    .brownout_detect        (bo),
    .watchdog_timeout       (wd),
    .brownout_detect_enable (brownout_detect_enable),
    .startup_delay_disable  (startup_delay_disable),
    .osc_mode               (osc_mode),
    .sleep_req              (sleep_req),
    .irq_wake               (irq_wake),
    .global_irq_enable      (global_irq_enable),
    .pc_current             (pc_current),
    .avs_address            (avs_address),
    .avs_read               (avs_read),
    .avs_write              (avs_write),
    .avs_writedata          (avs_writedata),
    .avs_byteenable         (4'hF),
    .avs_readdata           (avs_readdata),
    .avs_waitrequest        (avs_waitrequest),
    .core_reset_q           (core_reset_q),
    .pc_load_q              (pc_load_q),
    .pc_value_q             (pc_value_q),
    .option_q               (option_q),
    .irq_q                  (irq_q)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // Bus and sequencing tasks
  // ----------------------------------------
  task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : av_wr

  task automatic chk_rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    @(posedge clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    `CHK(d & m, e)
  endtask : chk_rd

  task automatic wait_load();
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pc_load_q !== 1'b1 && n < 400);
    pc = pc_value_q;
    `CHK(n < 400, 1'b1)
  endtask : wait_load

  task automatic chk_flags(input logic [1:0] p, input logic [1:0] s, input logic [2:0] c);
    chk_rd(5'h00, 32'h0000_0003, {30'h0, p});
    chk_rd(5'h04, 32'h0000_0018, {27'h0, s, 3'h0});
    chk_rd(5'h08, 32'h0000_0007, {29'h0, c});
  endtask : chk_flags

  // Kinds: 0 brown-out, 1 watchdog, 2 pin, 3 pin asleep, 4 watchdog wake, 5/6 irq wake
  task automatic run_case(input int k, input logic [12:0] epc, input logic [1:0] ep,
                          input logic [1:0] es, input logic [2:0] ec, input logic [7:0] eo);
    av_wr(5'h14, 32'h0000_005A);
    av_wr(5'h04, 32'h0000_00E0);
    global_irq_enable <= (k == 6);
    if (k >= 3)
    begin
      @(posedge clk);
      sleep_req <= 1'b1;
      @(posedge clk);
      sleep_req <= 1'b0;
      repeat (4) @(posedge clk);
    end
    case (k)
      0: u_partner.brownout(10);
      1, 4: u_partner.expire();
      2, 3: u_partner.pin_low(5);
      default:
      begin
        @(posedge clk);
        irq_wake <= 1'b1;
        @(posedge clk);
        irq_wake <= 1'b0;
      end
    endcase
    wait_load();
    `CHK(pc, epc)
    `CHK(option_q, eo)
    chk_flags(ep, es, ec);
    chk_rd(5'h04, 32'h0000_00E0, {24'h0, ((k >= 4) ? 8'hE0 : 8'h00)});
    av_wr(5'h00, 32'h0000_0003);
  endtask : run_case

  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  initial
  begin
    #200000;
    error_cnt++;
    conclude();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    error_cnt = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    brownout_detect_enable = 1'b1;
    startup_delay_disable = 1'b0;
    osc_mode = OSC_CRYSTAL_MID;
    sleep_req = 1'b0;
    irq_wake = 1'b0;
    global_irq_enable = 1'b0;
    pc_current = 13'h0123;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (12) @(posedge clk);
    `CHK(core_reset_q, 1'b1)
    sys_rst <= 1'b0;
    wait_load();
    `CHK((n >= PWRT + OST) && (n <= PWRT + OST + 6), 1'b1)
    `CHK(pc, 13'h0000)
    chk_flags(2'b01, 2'b11, CAUSE_POWER_ON);
    chk_rd(5'h14, 32'h0000_00FF, 32'h0000_00FF);
    chk_rd(5'h0C, 32'h0000_0001, 32'h0000_0001);
    chk_rd(5'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
    av_wr(5'h00, 32'h0000_0003);
    chk_rd(5'h00, 32'h0000_0003, 32'h0000_0003);
    run_case(0, 13'h0000, 2'b10, 2'b11, CAUSE_BROWNOUT, 8'hFF);
    `CHK((n >= PWRT + OST) && (n <= PWRT + OST + 6), 1'b1)
    run_case(1, 13'h0000, 2'b11, 2'b01, CAUSE_WDT_RESET, 8'hFF);
    run_case(2, 13'h0000, 2'b11, 2'b01, CAUSE_EXT_RUN, 8'hFF);
    run_case(3, 13'h0000, 2'b11, 2'b10, CAUSE_EXT_SLEEP, 8'hFF);
    run_case(4, 13'h0124, 2'b11, 2'b00, CAUSE_WDT_WAKE, 8'h5A);
    run_case(5, 13'h0124, 2'b11, 2'b10, CAUSE_IRQ_WAKE, 8'h5A);
    `CHK(irq_q, 1'b0)
    av_wr(5'h10, 32'h0000_0020);
    repeat (3) @(posedge clk);
    `CHK(irq_q, 1'b1)
    chk_rd(5'h0C, 32'h0000_0020, 32'h0000_0020);
    repeat (3) @(posedge clk);
    `CHK(irq_q, 1'b0)
    run_case(6, 13'h0004, 2'b11, 2'b10, CAUSE_IRQ_WAKE, 8'h5A);
    osc_mode <= OSC_RES_CAP;
    startup_delay_disable <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wait_load();
    `CHK(n <= 4, 1'b1)
    chk_flags(2'b01, 2'b11, CAUSE_POWER_ON);
    av_wr(5'h00, 32'h0000_0003);
    u_partner.brownout(10);
    wait_load();
    `CHK((n >= PWRT) && (n <= PWRT + 6), 1'b1)
    av_wr(5'h00, 32'h0000_0003);
    brownout_detect_enable <= 1'b0;
    u_partner.brownout(10);
    repeat (40) @(posedge clk);
    `CHK(core_reset_q, 1'b0)
    chk_rd(5'h00, 32'h0000_0003, 32'h0000_0003);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
